// *** cebx_core.sv ***
// Condition evaluation, data operations, branches and swap of a 32-bit core.
`timescale 1ns/10ps
`include "cebx_params.svh"
module cebx_core
   import cebx_pkg::*;
(
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_sys_rst,
   // Instruction stream
   input  wire logic        i_instr_valid,
   input  wire logic [31:0] i_instr,
   output logic             o_instr_ready,
   output logic             o_retired,
   output logic             o_skipped,
   // Program flow
   output logic [31:0]      o_pc,
   output logic             o_flush,
   output logic             o_nonseq,
   output logic             o_compact_state,
   output logic [3:0]       o_flags,
   // Data memory
   output logic             o_mem_req,
   output logic             o_mem_we,
   output logic [31:0]      o_mem_addr,
   output logic [31:0]      o_mem_wdata,
   input  wire logic        i_mem_ack,
   input  wire logic [31:0] i_mem_rdata,
   // Register inspection
   input  wire logic [3:0]  i_dbg_idx,
   output logic [31:0]      o_dbg_data
);

   cebx_regs_s  s_r;
   cebx_regs_s  s_nxt;
   logic        take;
   logic        pass;
   logic        is_bx;
   logic        is_swp;
   logic        is_mrs;
   logic        is_msr;
   logic        is_br;
   logic        is_dp;
   logic [3:0]  cc;
   logic [3:0]  opc;
   logic [31:0] op_a;
   logic [31:0] op_b;
   logic [31:0] rm_val;
   logic [63:0] rot_imm;
   logic [32:0] sum;
   logic [31:0] res;
   logic        arith;
   logic [31:0] br_target;
   logic [31:0] bx_target;

   // Reading the program counter yields the prefetch address two words ahead.
   function automatic logic [31:0] reg_rd(input cebx_regs_s s, input logic [3:0] idx);
      if (idx == `CEBX_PC_IDX) begin
         return s.pc + `CEBX_PC_AHEAD;
      end
      return s.regs[idx];
   endfunction

   function automatic logic [32:0] addc(input logic [31:0] a, input logic [31:0] b,
                                        input logic cin);
      return {1'b0, a} + {1'b0, b} + {32'h0, cin};
   endfunction

   function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f);
      logic n;
      logic z;
      logic cy;
      logic v;
      n  = f[`CEBX_FN];
      z  = f[`CEBX_FZ];
      cy = f[`CEBX_FC];
      v  = f[`CEBX_FV];
      case (c)
         // RULE2: single flag tests.
         `CEBX_CC_EQ: return z;
         `CEBX_CC_NE: return !z;
         `CEBX_CC_CS: return cy;
         `CEBX_CC_CC: return !cy;
         `CEBX_CC_MI: return n;
         `CEBX_CC_PL: return !n;
         `CEBX_CC_VS: return v;
         `CEBX_CC_VC: return !v;
         // RULE3: unsigned compare codes.
         `CEBX_CC_HI: return cy && !z;
         `CEBX_CC_LS: return !cy || z;
         // RULE4: signed compare codes.
         `CEBX_CC_GE: return n == v;
         `CEBX_CC_LT: return n != v;
         `CEBX_CC_GT: return !z && (n == v);
         `CEBX_CC_LE: return z || (n != v);
         // RULE5: always executes.
         `CEBX_CC_AL: return 1'b1;
         // RULE6: reserved code is never issued, so it is simply treated as failing.
         default:     return 1'b0;
      endcase
   endfunction

   // Decode of the wide instruction set.
   always_comb begin
      take   = i_instr_valid && s_r.rdy;
      cc     = i_instr[`CEBX_F_COND];
      opc    = i_instr[`CEBX_F_OPC];
      // RULE20: flags register already holds every earlier result.
      pass   = cond_ok(cc, s_r.flags);
      is_bx  = i_instr[`CEBX_F_BXBODY] == `CEBX_BX_PAT;
      is_swp = i_instr[`CEBX_F_SWPHI] == `CEBX_SWPHI_PAT
               && i_instr[`CEBX_F_SWPMID] == `CEBX_SWPMID_PAT
               && i_instr[`CEBX_F_LO8] == `CEBX_SWPLO_PAT;
      is_mrs = i_instr[`CEBX_F_SWPHI] == `CEBX_SWPHI_PAT
               && i_instr[`CEBX_F_MRSMID] == `CEBX_MRS_PAT
               && i_instr[`CEBX_F_LO8] == `CEBX_PSRLO_PAT;
      is_msr = i_instr[`CEBX_F_SWPHI] == `CEBX_SWPHI_PAT
               && i_instr[`CEBX_F_MSRMID] == `CEBX_MSR_PAT
               && i_instr[`CEBX_F_LO8] == `CEBX_PSRLO_PAT;
      is_br  = i_instr[`CEBX_F_CLS] == `CEBX_CLS_BR;
      is_dp  = i_instr[`CEBX_F_CLS] == 3'h0 || i_instr[`CEBX_F_CLS] == 3'h1;
      rm_val = reg_rd(s_r, i_instr[`CEBX_F_RM]);
      op_a   = reg_rd(s_r, i_instr[`CEBX_F_RN]);
      // Immediate operand is an 8-bit value rotated right by twice the rotate field.
      rot_imm = {24'h0, i_instr[`CEBX_F_IMM], 24'h0, i_instr[`CEBX_F_IMM]}
                >> {i_instr[`CEBX_F_ROT], 1'b0};
      // Register operands are taken unshifted; the shift field is not decoded.
      op_b   = i_instr[`CEBX_F_IBIT] ? rot_imm[31:0] : rm_val;
      br_target = s_r.pc + `CEBX_PC_AHEAD
                  + {{6{i_instr[23]}}, i_instr[`CEBX_F_BOFS], 2'h0};
      bx_target = rm_val;
      arith = 1'b1;
      sum   = 33'h0;
      res   = 32'h0;
      case (opc)
         `CEBX_OP_AND, `CEBX_OP_TST: begin
            arith = 1'b0;
            res   = op_a & op_b;
         end
         // RULE14: exclusive-or result.
         `CEBX_OP_EOR, `CEBX_OP_TEQ: begin
            arith = 1'b0;
            res   = op_a ^ op_b;
         end
         `CEBX_OP_SUB, `CEBX_OP_CMP: begin
            sum = addc(op_a, ~op_b, 1'b1);
         end
         `CEBX_OP_RSB: begin
            sum = addc(op_b, ~op_a, 1'b1);
         end
         `CEBX_OP_ADD, `CEBX_OP_CMN: begin
            sum = addc(op_a, op_b, 1'b0);
         end
         // RULE11: add with carry in.
         `CEBX_OP_ADC: begin
            sum = addc(op_a, op_b, s_r.flags[`CEBX_FC]);
         end
         // RULE12: borrow is the inverted carry.
         `CEBX_OP_SBC: begin
            sum = addc(op_a, ~op_b, s_r.flags[`CEBX_FC]);
         end
         `CEBX_OP_RSC: begin
            sum = addc(op_b, ~op_a, s_r.flags[`CEBX_FC]);
         end
         `CEBX_OP_ORR: begin
            arith = 1'b0;
            res   = op_a | op_b;
         end
         `CEBX_OP_MOV: begin
            arith = 1'b0;
            res   = op_b;
         end
         // RULE13: bit clear.
         `CEBX_OP_BIC: begin
            arith = 1'b0;
            res   = op_a & ~op_b;
         end
         // RULE17: move inverted.
         default: begin
            arith = 1'b0;
            res   = ~op_b;
         end
      endcase
      if (arith) begin
         res = sum[31:0];
      end
   end

   // Next-state logic.
   always_comb begin
      s_nxt         = s_r;
      s_nxt.retired = 1'b0;
      s_nxt.skipped = 1'b0;
      s_nxt.flush   = 1'b0;
      s_nxt.dbg     = reg_rd(s_r, i_dbg_idx);
      case (s_r.st)
         st_idle: begin
            if (take) begin
               s_nxt.pc = s_r.pc + (s_r.tbit ? `CEBX_STEP_CMPT : `CEBX_STEP_WIDE);
               // RULE1: failing or compact-state instructions are ignored.
               if (s_r.tbit || !pass) begin
                  s_nxt.skipped = 1'b1;
               end else if (is_bx) begin
                  // RULE7: load PC from the register and refill.
                  s_nxt.pc      = bx_target & `CEBX_ALIGN_H;
                  s_nxt.flush   = 1'b1;
                  s_nxt.retired = 1'b1;
                  s_nxt.st      = st_br_n;
                  // RULE8: bit 0 selects the decoding state.
                  s_nxt.tbit    = bx_target[0];
               end else if (is_swp) begin
                  // RULE18: read phase first; source held for the store phase.
                  s_nxt.mem_req   = 1'b1;
                  s_nxt.mem_we    = 1'b0;
                  s_nxt.mem_addr  = op_a;
                  s_nxt.mem_wdata = rm_val;
                  s_nxt.swp_rd    = i_instr[`CEBX_F_RD];
                  s_nxt.st        = st_swp_rd;
               end else if (is_mrs) begin
                  // RULE19: status word into a register.
                  s_nxt.retired = 1'b1;
                  if (i_instr[`CEBX_F_RD] != `CEBX_PC_IDX) begin
                     s_nxt.regs[i_instr[`CEBX_F_RD]] = 32'h0;
                     s_nxt.regs[i_instr[`CEBX_F_RD]][`CEBX_PSR_FLAGS] = s_r.flags;
                     s_nxt.regs[i_instr[`CEBX_F_RD]][`CEBX_PSR_TBIT]  = s_r.tbit;
                  end
               end else if (is_msr) begin
                  // RULE19: register into the status flags.
                  s_nxt.retired = 1'b1;
                  s_nxt.flags   = rm_val[`CEBX_PSR_FLAGS];
               end else if (is_br) begin
                  s_nxt.retired = 1'b1;
                  // RULE16: link gets the following instruction address.
                  if (i_instr[`CEBX_F_LINK]) begin
                     s_nxt.regs[`CEBX_LR_IDX] = (s_r.pc + `CEBX_STEP_WIDE) & `CEBX_ALIGN_W;
                  end
                  s_nxt.pc    = br_target;
                  s_nxt.flush = 1'b1;
                  s_nxt.st    = st_br_n;
               end else if (is_dp) begin
                  s_nxt.retired = 1'b1;
                  // RULE15: flag update; test group writes no register.
                  if (i_instr[`CEBX_F_SBIT]) begin
                     s_nxt.flags[`CEBX_FN] = res[31];
                     s_nxt.flags[`CEBX_FZ] = res == 32'h0;
                     if (arith) begin
                        s_nxt.flags[`CEBX_FC] = sum[32];
                        // Reverse forms take their sign reference from the second operand.
                        s_nxt.flags[`CEBX_FV] = (sum[31] ^ ((opc == `CEBX_OP_RSB
                           || opc == `CEBX_OP_RSC) ? op_b[31] : op_a[31]))
                           & ~(op_a[31] ^ op_b[31] ^ (opc == `CEBX_OP_SUB
                              || opc == `CEBX_OP_SBC || opc == `CEBX_OP_CMP
                              || opc == `CEBX_OP_RSB || opc == `CEBX_OP_RSC));
                     end
                  end
                  if (opc[`CEBX_F_OPGRP] != `CEBX_GRP_TEST) begin
                     if (i_instr[`CEBX_F_RD] == `CEBX_PC_IDX) begin
                        s_nxt.pc    = res & `CEBX_ALIGN_W;
                        s_nxt.flush = 1'b1;
                        s_nxt.st    = st_br_n;
                     end else begin
                        s_nxt.regs[i_instr[`CEBX_F_RD]] = res;
                     end
                  end
               end else begin
                  // Memory block, coprocessor and other forms are not handled here.
                  s_nxt.skipped = 1'b1;
               end
            end
         end
         // RULE9: one non-sequential then two sequential refill cycles.
         st_br_n: begin
            s_nxt.st = st_br_s1;
         end
         st_br_s1: begin
            s_nxt.st = st_br_s2;
         end
         st_br_s2: begin
            s_nxt.st = st_idle;
         end
         st_swp_rd: begin
            if (i_mem_ack) begin
               if (s_r.swp_rd != `CEBX_PC_IDX) begin
                  s_nxt.regs[s_r.swp_rd] = i_mem_rdata;
               end
               // RULE18: store the source to the same address.
               s_nxt.mem_we = 1'b1;
               s_nxt.st     = st_swp_wr;
            end
         end
         st_swp_wr: begin
            if (i_mem_ack) begin
               s_nxt.mem_req = 1'b0;
               s_nxt.mem_we  = 1'b0;
               s_nxt.retired = 1'b1;
               s_nxt.st      = st_idle;
            end
         end
         default: begin
            s_nxt.st = st_idle;
         end
      endcase
      s_nxt.rdy  = s_nxt.st == st_idle;
      s_nxt.nseq = s_nxt.st == st_br_n;
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign o_instr_ready   = s_r.rdy;
   assign o_retired       = s_r.retired;
   assign o_skipped       = s_r.skipped;
   assign o_pc            = s_r.pc;
   assign o_flush         = s_r.flush;
   assign o_nonseq        = s_r.nseq;
   assign o_compact_state = s_r.tbit;
   assign o_flags         = s_r.flags;
   assign o_mem_req       = s_r.mem_req;
   assign o_mem_we        = s_r.mem_we;
   assign o_mem_addr      = s_r.mem_addr;
   assign o_mem_wdata     = s_r.mem_wdata;
   assign o_dbg_data      = s_r.dbg;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   logic wide_take;
   assign wide_take = take && !s_r.tbit;

   chk_cond_skip: assert property (wide_take && !pass |=> o_skipped // RULE1
      && o_pc == $past(o_pc) + `CEBX_STEP_WIDE) else $error("failed condition not ignored");
   chk_zero_clear: assert property (wide_take && cc == `CEBX_CC_NE // RULE2
      && s_r.flags[`CEBX_FZ] |=> o_skipped) else $error("zero-clear passed with Z set");
   chk_unsigned_hi: assert property (wide_take && cc == `CEBX_CC_HI && is_dp && !is_swp // RULE3
      && s_r.flags[`CEBX_FC] && !s_r.flags[`CEBX_FZ] |=> o_retired)
      else $error("unsigned-above not executed");
   chk_signed_gt: assert property (wide_take && cc == `CEBX_CC_GT // RULE4
      && (s_r.flags[`CEBX_FZ] || s_r.flags[`CEBX_FN] != s_r.flags[`CEBX_FV])
      |=> o_skipped) else $error("signed-above passed wrongly");
   chk_always_run: assert property (wide_take && cc == `CEBX_CC_AL // RULE5
      |=> !o_skipped || $past(!(is_bx || is_swp || is_mrs || is_msr || is_br || is_dp)))
      else $error("always code ignored");
   chk_bx_target: assert property (wide_take && pass && is_bx // RULE7
      |=> o_flush && o_pc == ($past(bx_target) & `CEBX_ALIGN_H))
      else $error("branch-swap target wrong");
   chk_bx_state: assert property (wide_take && pass && is_bx // RULE8
      |=> o_compact_state == $past(bx_target[0])) else $error("state bit not copied");
   chk_bx_cycles: assert property (wide_take && pass && is_bx // RULE9
      |=> o_nonseq ##1 (!o_nonseq && !o_instr_ready) ##1 !o_instr_ready ##1 o_instr_ready)
      else $error("branch-swap cycle count wrong");
   chk_cmp_zero: assert property (wide_take && pass && is_dp && opc == `CEBX_OP_CMP // RULE15
      && i_instr[`CEBX_F_SBIT] && op_a == op_b |=> o_flags[`CEBX_FZ] && o_flags[`CEBX_FC])
      else $error("compare flags wrong");
   chk_swap_order: assert property (wide_take && pass && is_swp // RULE18
      |=> o_mem_req && !o_mem_we && o_mem_addr == $past(op_a))
      else $error("swap did not read first");

   cov_bx_compact: cover property (wide_take && pass && is_bx && bx_target[0]);
   cov_skip: cover property (wide_take && !pass);
   cov_swap_done: cover property (s_r.st == st_swp_wr && i_mem_ack);
endmodule

// *** cebx_params.svh ***
// Constants for the conditional execution and branch-exchange core.
// Operation
// RULE1: Check condition bits 31:28 against N Z C V; execute only on pass, else ignore.
// RULE2: Codes 0000-0111 test Z, C, N, V set or clear in turn.
// RULE3: Code 1000 needs C set and Z clear; 1001 needs C clear or Z set.
// RULE4: 1010 N==V, 1011 N!=V, 1100 Z clear and N==V, 1101 Z set or N!=V.
// RULE5: Code 1110 always executes regardless of the flags.
// RULE6: Software never issues condition code 1111.
// RULE7: Passing branch-state-swap loads PC from the register and flushes the pipeline.
// RULE8: Branch-state-swap copies register bit 0 into the compact-state select bit.
// RULE9: Branch-state-swap takes two sequential cycles plus one non-sequential cycle.
// RULE10: Software never names the program counter as the branch-state-swap operand.
// RULE11: Add-with-carry writes first operand plus second operand plus carry.
// RULE12: Subtract-with-carry is a minus b minus not carry; reverse swaps operands.
// RULE13: Bit-clear writes first operand AND NOT second operand.
// RULE14: Exclusive-or writes bits set in exactly one operand.
// RULE15: Compare and test ops update flags only, from sub, add, xor, and.
// RULE16: Branch-with-link saves the program counter in the link register, then branches.
// RULE17: Move-inverted writes the complement of the second operand.
// RULE18: Swap loads destination from memory at base, then stores source there.
// RULE19: Status-write copies a register into the status word; status-read copies back.
// RULE20: Conditions see the flags left by every earlier instruction.
`ifndef CEBX_PARAMS_SVH
`define CEBX_PARAMS_SVH
`define CEBX_F_COND    31:28
`define CEBX_F_CLS     27:25
`define CEBX_F_IBIT    25
`define CEBX_F_LINK    24
`define CEBX_F_OPC     24:21
`define CEBX_F_SBIT    20
`define CEBX_F_RN      19:16
`define CEBX_F_RD      15:12
`define CEBX_F_ROT     11:8
`define CEBX_F_IMM     7:0
`define CEBX_F_RM      3:0
`define CEBX_F_BOFS    23:0
`define CEBX_F_BXBODY  27:4
`define CEBX_F_SWPHI   27:23
`define CEBX_F_SWPMID  21:20
`define CEBX_F_LO8     11:4
`define CEBX_F_MRSMID  21:16
`define CEBX_F_MSRMID  21:12
`define CEBX_F_OPGRP   3:2
`define CEBX_BX_PAT    24'h12FFF1
`define CEBX_SWPHI_PAT 5'h02
`define CEBX_SWPMID_PAT 2'h0
`define CEBX_SWPLO_PAT 8'h09
`define CEBX_PSRLO_PAT 8'h00
`define CEBX_MRS_PAT   6'h0F
`define CEBX_MSR_PAT   10'h29F
`define CEBX_CLS_BR    3'h5
`define CEBX_GRP_TEST  2'h2
`define CEBX_PC_IDX    4'hF
`define CEBX_LR_IDX    4'hE
`define CEBX_PC_AHEAD  32'h8
`define CEBX_STEP_WIDE 32'h4
`define CEBX_STEP_CMPT 32'h2
`define CEBX_ALIGN_W   32'hFFFFFFFC
`define CEBX_ALIGN_H   32'hFFFFFFFE
`define CEBX_PSR_FLAGS 31:28
`define CEBX_PSR_TBIT  5
`define CEBX_FN 3
`define CEBX_FZ 2
`define CEBX_FC 1
`define CEBX_FV 0
`define CEBX_CC_EQ 4'h0
`define CEBX_CC_NE 4'h1
`define CEBX_CC_CS 4'h2
`define CEBX_CC_CC 4'h3
`define CEBX_CC_MI 4'h4
`define CEBX_CC_PL 4'h5
`define CEBX_CC_VS 4'h6
`define CEBX_CC_VC 4'h7
`define CEBX_CC_HI 4'h8
`define CEBX_CC_LS 4'h9
`define CEBX_CC_GE 4'hA
`define CEBX_CC_LT 4'hB
`define CEBX_CC_GT 4'hC
`define CEBX_CC_LE 4'hD
`define CEBX_CC_AL 4'hE
`define CEBX_OP_AND 4'h0
`define CEBX_OP_EOR 4'h1
`define CEBX_OP_SUB 4'h2
`define CEBX_OP_RSB 4'h3
`define CEBX_OP_ADD 4'h4
`define CEBX_OP_ADC 4'h5
`define CEBX_OP_SBC 4'h6
`define CEBX_OP_RSC 4'h7
`define CEBX_OP_TST 4'h8
`define CEBX_OP_TEQ 4'h9
`define CEBX_OP_CMP 4'hA
`define CEBX_OP_CMN 4'hB
`define CEBX_OP_ORR 4'hC
`define CEBX_OP_MOV 4'hD
`define CEBX_OP_BIC 4'hE
`define CEBX_OP_MVN 4'hF
`endif

// *** cebx_pkg.sv ***
// Types shared by the conditional execution and branch-exchange core.
package cebx_pkg;
   typedef enum logic [2:0] {
      st_idle, st_br_n, st_br_s1, st_br_s2, st_swp_rd, st_swp_wr
   } cebx_state_e;

   typedef struct packed {
      cebx_state_e       st;
      logic [31:0]       pc;
      logic [3:0]        flags;
      logic              tbit;
      logic [14:0][31:0] regs;
      logic              rdy;
      logic              retired;
      logic              skipped;
      logic              flush;
      logic              nseq;
      logic              mem_req;
      logic              mem_we;
      logic [31:0]       mem_addr;
      logic [31:0]       mem_wdata;
      logic [3:0]        swp_rd;
      logic [31:0]       dbg;
   } cebx_regs_s;
endpackage

// *** cebx_tb.sv ***
// Self-checking bench for the conditional execution and branch-exchange core.
`timescale 1ns/10ps
module testbench;
   logic        i_clk;
   logic        i_sys_rst;
   logic        i_instr_valid;
   logic [31:0] i_instr;
   logic        i_mem_ack;
   logic [31:0] i_mem_rdata;
   logic [3:0]  i_dbg_idx;
   logic        o_instr_ready;
   logic        o_retired;
   logic        o_skipped;
   logic [31:0] o_pc;
   logic        o_flush;
   logic        o_nonseq;
   logic        o_compact_state;
   logic [3:0]  o_flags;
   logic        o_mem_req;
   logic        o_mem_we;
   logic [31:0] o_mem_addr;
   logic [31:0] o_mem_wdata;
   logic [31:0] o_dbg_data;
   logic        got_ret;
   logic        got_skip;
   logic [31:0] pc_was;
   logic [7:0]  seq;
   logic [3:0]  ops [6];
   int          n_errors;
   int          tests_run;

   cebx_core dut_u (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_instr_valid(i_instr_valid),
      .i_instr(i_instr), .o_instr_ready(o_instr_ready), .o_retired(o_retired),
      .o_skipped(o_skipped), .o_pc(o_pc), .o_flush(o_flush), .o_nonseq(o_nonseq),
      .o_compact_state(o_compact_state), .o_flags(o_flags), .o_mem_req(o_mem_req),
      .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
      .i_mem_ack(i_mem_ack), .i_mem_rdata(i_mem_rdata), .i_dbg_idx(i_dbg_idx),
      .o_dbg_data(o_dbg_data)
   );

   function automatic logic [31:0] dp(input logic [3:0] cc, op, rn, rd, rm, input logic s);
      return {cc, 3'h0, op, s, rn, rd, 8'h00, rm};
   endfunction

   function automatic logic [31:0] movi(input logic [3:0] cc, rd, rot, input logic [7:0] imm);
      return {cc, 3'h1, 4'hD, 1'h0, 4'h0, rd, rot, imm};
   endfunction

   function automatic logic pass(input logic [3:0] cc, input logic [3:0] f);
      logic        n, z, c, v;
      logic [15:0] t;
      {n, z, c, v} = f;
      t = {1'b0, 1'b1, z | (n ^ v), ~z & ~(n ^ v), n ^ v, ~(n ^ v), ~c | z, c & ~z,
           ~v, v, ~n, n, ~c, c, ~z, z};
      return t[cc];
   endfunction

   function automatic logic [31:0] alu(input logic [3:0] op, input logic [31:0] a, b,
                                       input logic c);
      case (op)
         4'h5: return a + b + {31'h0, c};
         4'h6: return a - b - {31'h0, !c};
         4'h7: return b - a - {31'h0, !c};
         4'hE: return a & ~b;
         4'h1: return a ^ b;
         default: return ~b;
      endcase
   endfunction

   function automatic logic [3:0] cmpf(input logic [3:0] op, input logic [31:0] a, b,
                                       input logic [3:0] f);
      logic [32:0] r;
      logic        v;
      case (op)
         4'h8: r = {f[1], a & b};
         4'h9: r = {f[1], a ^ b};
         4'hA: r = {1'b0, a} + {1'b0, ~b} + 33'h1;
         default: r = {1'b0, a} + {1'b0, b};
      endcase
      v = (op[0] ? a[31] == b[31] : a[31] != b[31]) && (r[31] != a[31]);
      return {r[31], r[31:0] == 32'h0, r[32], (op[1] ? v : f[0])};
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out;
      if (n_errors == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Offers one instruction, waits a bounded time for ready, samples the answer.
   task automatic take(input logic [31:0] ins);
      int n;
      n = 0;
      @(negedge i_clk);
      i_instr = ins;
      i_instr_valid = 1'b1;
      while (o_instr_ready !== 1'b1 && n < 20) begin
         @(negedge i_clk);
         n++;
      end
      if (n == 20) n_errors++;
      @(negedge i_clk);
      i_instr_valid = 1'b0;
      i_instr = ~ins;
      got_ret = o_retired;
      got_skip = o_skipped;
   endtask

   task automatic rd_reg(input logic [3:0] idx, input logic [31:0] exp);
      @(negedge i_clk);
      i_dbg_idx = idx;
      repeat (2) @(negedge i_clk);
      chk(o_dbg_data, exp);
   endtask

   task automatic set_flags(input logic [3:0] f);
      take(movi(4'hE, 4'h9, 4'h2, {4'h0, f}));
      take({4'hE, 5'h02, 1'h0, 10'h29F, 8'h00, 4'h9});
   endtask

   // The far side holds the request waiting two cycles before each ack.
   task automatic mem_phase(input logic we, input logic [31:0] rdata);
      int n;
      n = 0;
      while (o_mem_req !== 1'b1 && n < 20) begin
         @(negedge i_clk);
         n++;
      end
      repeat (2) @(negedge i_clk);
      chk({o_mem_req, o_mem_we, o_mem_addr[29:0]}, {1'b1, we, 30'h40});
      if (we) chk(o_mem_wdata, 32'h5A);
      i_mem_ack = 1'b1;
      i_mem_rdata = rdata;
      @(negedge i_clk);
      i_mem_ack = 1'b0;
      i_mem_rdata = ~rdata;
   endtask

   task automatic do_reset;
      i_sys_rst = 1'b1;
      repeat (4) @(negedge i_clk);
      i_sys_rst = 1'b0;
      chk(o_pc, 32'h0);
      chk({20'h0, o_flags, o_compact_state, o_instr_ready, o_retired, o_skipped, o_flush,
           o_nonseq, o_mem_req, o_mem_we}, 32'h0);
   endtask

   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end

   // A run of under a thousand cycles is expected.
   initial begin
      repeat (30000) @(posedge i_clk);
      n_errors++;
      close_out();
   end

   initial begin
      i_sys_rst = 1'b1;
      i_instr_valid = 1'b0;
      i_instr = 32'h0;
      i_mem_ack = 1'b0;
      i_mem_rdata = 32'h0;
      i_dbg_idx = 4'h0;
      n_errors = 0;
      tests_run = 0;
      ops = '{4'h5, 4'h6, 4'h7, 4'hE, 4'h1, 4'hF};
      do_reset();
      // the first conditional follows the flag write directly.
      for (int f = 0; f < 16; f++) begin
         set_flags(f[3:0]);
         chk({28'h0, o_flags}, {28'h0, f[3:0]});
         // the reserved condition code is never offered.
         for (int cc = 0; cc < 15; cc++) begin
            take(movi(cc[3:0], 4'h3, 4'h0, 8'h11));
            chk({got_ret, got_skip}, {pass(cc[3:0], f[3:0]), !pass(cc[3:0], f[3:0])});
         end
      end
      take(movi(4'hE, 4'h1, 4'h4, 8'hFF));
      take(movi(4'hE, 4'h2, 4'h0, 8'h3C));
      for (int c = 0; c < 2; c++) begin
         foreach (ops[k]) begin
            set_flags({2'h0, c[0], 1'h0});
            take(dp(4'hE, ops[k], 4'h1, 4'hA, 4'h2, 1'b0));
            rd_reg(4'hA, alu(ops[k], 32'hFF000000, 32'h3C, c[0]));
         end
      end
      for (int op = 8; op < 12; op++) begin
         set_flags(4'h3);
         take(dp(4'hE, op[3:0], 4'h1, 4'h7, 4'h2, 1'b1));
         chk({28'h0, o_flags}, {28'h0, cmpf(op[3:0], 32'hFF000000, 32'h3C, 4'h3)});
      end
      rd_reg(4'h7, 32'h0);
      set_flags(4'h5);
      take({4'hE, 5'h02, 1'h0, 6'h0F, 4'h8, 12'h000});
      rd_reg(4'h8, 32'h50000000);
      pc_was = o_pc;
      take({4'hE, 4'hB, 24'h000010});
      chk({o_pc[30:0], o_flush}, {pc_was[30:0] + 31'h48, 1'b1});
      rd_reg(4'hE, pc_was + 32'h4);
      take(movi(4'hE, 4'h5, 4'h0, 8'h40));
      take(movi(4'hE, 4'h6, 4'h0, 8'h5A));
      take({4'hE, 5'h02, 1'h0, 2'h0, 4'h5, 4'h7, 8'h09, 4'h6});
      mem_phase(1'b0, 32'h12345678);
      mem_phase(1'b1, 32'h0);
      chk({31'h0, o_retired}, 32'h1);
      rd_reg(4'h7, 32'h12345678);
      set_flags(4'h0);
      take(movi(4'hE, 4'h4, 4'h0, 8'h81));
      pc_was = o_pc;
      // the branch-state-swap operand is r4, never the program counter.
      take({4'h0, 24'h12FFF1, 4'h4});
      chk({got_ret, got_skip, o_pc[29:0]}, {2'h1, pc_was[29:0] + 30'h4});
      take({4'hE, 24'h12FFF1, 4'h4});
      chk({o_pc[29:0], got_ret, o_flush}, {30'h80, 2'h3});
      chk({31'h0, o_compact_state}, 32'h1);
      seq = {6'h0, o_nonseq, o_instr_ready};
      repeat (3) begin
         @(negedge i_clk);
         seq = {seq[5:0], o_nonseq, o_instr_ready};
      end
      chk({24'h0, seq}, 32'h81);
      take(movi(4'hE, 4'h3, 4'h0, 8'h01));
      chk({got_ret, got_skip, o_pc[29:0]}, {2'h1, 30'h82});
      do_reset();
      close_out();
   end
endmodule
